// ### hdl/ssp_top.sv
// status flags, data registers and shifters of the synchronous serial port
// assumes an APB master on pclk and an external codec driving bit clocks and frame syncs
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_top (
    input wire logic pclk,                    // APB clock, 10 MHz
    input wire logic presetn,                 // async reset, active low
    input wire logic [11:0] paddr,            // byte address
    input wire logic psel,                    // slave select
    input wire logic penable,                 // access phase
    input wire logic pwrite,                  // write when high
    input wire logic [31:0] pwdata,           // write data
    output logic [31:0] prdata,               // read data
    output logic pready,                      // always ready
    output logic pslverr,                     // unmapped address
    input ssp_pkg::ssp_link_t link,           // serial link pins
    input wire logic stop_req,                // stop reset, active high
    output logic tx_data_pin,                 // serial data out
    output logic tx_data_pin_oe,              // high while driving
    output logic rx_irq,                      // receive data request
    output logic rx_err_irq,                  // overrun request
    output logic tx_irq,                      // transmit empty request
    output logic tx_err_irq                   // underrun request
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] ssp_wl_bits(input logic [1:0] code);
        if (code == `SSP_WL8)
        begin
            return 5'd8;
        end
        else if (code == `SSP_WL12)
        begin
            return 5'd12;
        end
        return 5'd16;
    endfunction : ssp_wl_bits

    // left-align a received word and zero the unused low bits
    function automatic logic [15:0] ssp_rx_align(input logic [15:0] sh, input logic [4:0] n,
                                                 input logic lsb);
        logic [4:0] gap;
        gap = 5'(5'd16 - n);
        if (lsb)
        begin
            return sh & (16'hFFFF << gap);
        end
        return sh << gap;
    endfunction : ssp_rx_align

    // place a left-aligned word so its first bit sits at the shift-out end
    function automatic logic [15:0] ssp_tx_load(input logic [15:0] w, input logic [4:0] n,
                                                input logic lsb);
        logic [4:0] gap;
        gap = 5'(5'd16 - n);
        return lsb ? (w >> gap) : w;
    endfunction : ssp_tx_load

    // ****************************************
    // state
    // ****************************************
    ssp_pkg::ssp_state_t s_q;
    ssp_pkg::ssp_state_t s_d;
    ssp_pkg::ssp_slot_ev_t rx_ev;
    ssp_pkg::ssp_slot_ev_t tx_ev;
    logic [31:0] rd_mux;
    logic hit;
    logic port_rst;
    logic sync_mode;
    logic network;
    logic lsb_first;
    logic [4:0] word_bits;
    logic rx_edge;
    logic tx_edge;
    logic tx_fs_sel;
    logic if0_en;
    logic if1_en;

    assign sync_mode = s_q.ctl[`SSP_CT_SYNC];
    assign network = s_q.ctl[`SSP_CT_NET];
    assign lsb_first = s_q.ctl[`SSP_CT_LSB];
    assign word_bits = ssp_wl_bits(s_q.ctl[`SSP_CT_WL_HI:`SSP_CT_WL_LO]);
    // port is in individual reset while no pin is given to the serial port
    assign port_rst = (s_q.port_pin_control[5:0] == 6'h00) || stop_req;
    // receive samples on the falling bit clock, transmit changes on the rising one
    assign rx_edge = !s_q.link_b.rx_clk && s_q.link_c.rx_clk
                     && s_q.ctl[`SSP_CT_RXEN];
    // synchronous mode borrows the receive clock and frame sync
    assign tx_edge = (sync_mode ? (s_q.link_b.rx_clk && !s_q.link_c.rx_clk)
                                : (s_q.link_b.tx_clk && !s_q.link_c.tx_clk))
                     && s_q.ctl[`SSP_CT_TXEN];
    assign tx_fs_sel = sync_mode ? s_q.link_b.rx_fs : s_q.link_b.tx_fs;
    assign if0_en = s_q.port_pin_control[`SSP_PC_PIN0] && sync_mode && !s_q.ctl[`SSP_CT_DIR0];
    assign if1_en = s_q.port_pin_control[`SSP_PC_PIN1] && sync_mode && !s_q.ctl[`SSP_CT_DIR1];

    ssp_slot u_rx_slot (
        .pclk(pclk),
        .presetn(presetn),
        .flush(port_rst),
        .bit_ev(rx_edge),
        .fs(s_q.link_b.rx_fs),
        .network(network),
        .word_bits(word_bits),
        .last_slot(s_q.ctl[`SSP_CT_SLOT_HI:`SSP_CT_SLOT_LO]),
        .ev(rx_ev)
    );

    ssp_slot u_tx_slot (
        .pclk(pclk),
        .presetn(presetn),
        .flush(port_rst),
        .bit_ev(tx_edge),
        .fs(tx_fs_sel),
        .network(network),
        .word_bits(word_bits),
        .last_slot(s_q.ctl[`SSP_CT_SLOT_HI:`SSP_CT_SLOT_LO]),
        .ev(tx_ev)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic wr;
        logic rd;
        logic [15:0] rx_next;
        logic [15:0] tx_cur;
        logic null_cur;
        wr = 1'b0;
        rd = 1'b0;
        rx_next = 16'h0000;
        tx_cur = 16'h0000;
        null_cur = 1'b0;
        s_d = s_q;

        // link pins pass two flops before anything reads them
        s_d.link_a = link;
        s_d.link_b = s_q.link_a;
        s_d.link_c = s_q.link_b;

        // APB decode and read mux
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `SSP_OFF_STATUS:
            begin
                // upper three bytes stay zero
                rd_mux = {24'h00_0000, s_q.rx_full, s_q.tx_empty, s_q.ovr, s_q.und,
                          s_q.rx_fsf, s_q.tx_frame_sync_flag, s_q.if1 && if1_en, s_q.if0 && if0_en};
            end
            `SSP_OFF_RXDATA: rd_mux = {16'h0000, s_q.rx_data};
            `SSP_OFF_TXDATA: rd_mux = 32'h0000_0000;
            `SSP_OFF_NULL: rd_mux = 32'h0000_0000;
            `SSP_OFF_PCR: rd_mux = {16'h0000, s_q.port_pin_control};
            `SSP_OFF_CTRL: rd_mux = {11'h000, s_q.ctl};
            default:
            begin
                hit = 1'b0;
            end
        endcase
        wr = psel && penable && pwrite && hit;
        rd = psel && penable && !pwrite && hit;

        // software clears first, so a same-cycle hardware set wins
        if (rd && paddr == `SSP_OFF_STATUS)
        begin
            s_d.ovr_arm = s_q.ovr_arm || s_q.ovr;
            s_d.und_arm = s_q.und_arm || s_q.und;
        end
        if (rd && paddr == `SSP_OFF_RXDATA)
        begin
            s_d.rx_full = 1'b0;
            if (s_q.ovr_arm)
            begin
                s_d.ovr = 1'b0;
                s_d.ovr_arm = 1'b0;
            end
        end
        if (wr && (paddr == `SSP_OFF_TXDATA || paddr == `SSP_OFF_NULL) && s_q.und_arm)
        begin
            s_d.und = 1'b0;
            s_d.und_arm = 1'b0;
        end

        // ****************************************
        // receive path
        // ****************************************
        rx_next = lsb_first ? {s_q.link_b.rx_data_pin, s_q.rx_sh[15:1]}
                            : {s_q.rx_sh[14:0], s_q.link_b.rx_data_pin};
        if (rx_ev.go)
        begin
            s_d.rx_sh = rx_next;
        end
        if (rx_ev.first)
        begin
            s_d.cap0 = s_q.link_b.ctrl_pin_zero;
            s_d.cap1 = s_q.link_b.ctrl_pin_one;
            s_d.rx_fcap = rx_ev.frame;
        end
        if (rx_ev.last)
        begin
            if (s_q.rx_full)
            begin
                // the new word is dropped and the held one kept
                s_d.ovr = 1'b1;
            end
            else
            begin
                s_d.rx_data = ssp_rx_align(rx_next, word_bits, lsb_first);
                s_d.rx_full = 1'b1;
                s_d.rx_fsf = s_q.rx_fcap;
                s_d.if0 = s_q.cap0;
                s_d.if1 = s_q.cap1;
            end
        end

        // ****************************************
        // transmit path
        // ****************************************
        tx_cur = s_q.tx_sh;
        null_cur = s_q.tx_null;
        if (tx_ev.first)
        begin
            s_d.tx_frame_sync_flag = tx_ev.frame;
            // the held word is reloaded either way; on underrun it is simply resent
            tx_cur = ssp_tx_load(s_q.tx_data, word_bits, lsb_first);
            if (s_q.tx_empty)
            begin
                s_d.und = 1'b1;
                null_cur = 1'b0;
            end
            else
            begin
                null_cur = s_q.null_pend;
                s_d.tx_empty = 1'b1;
                s_d.null_pend = 1'b0;
            end
            s_d.tx_null = null_cur;
        end
        if (tx_ev.go)
        begin
            s_d.pin = lsb_first ? tx_cur[0] : tx_cur[15];
            s_d.tx_sh = lsb_first ? (tx_cur >> 1) : (tx_cur << 1);
            s_d.oe = !null_cur && s_q.port_pin_control[`SSP_PC_PEN];
        end
        else if (tx_edge)
        begin
            s_d.oe = 1'b0;
        end

        // ****************************************
        // register writes
        // ****************************************
        if (wr)
        begin
            unique case (paddr)
                `SSP_OFF_TXDATA:
                begin
                    // a word written in the frame-sync slot goes out in the next slot
                    s_d.tx_data = pwdata[15:0];
                    s_d.tx_empty = 1'b0;
                    s_d.null_pend = 1'b0;
                end
                `SSP_OFF_NULL:
                begin
                    s_d.tx_empty = 1'b0;
                    s_d.null_pend = 1'b1;
                end
                `SSP_OFF_PCR: s_d.port_pin_control = pwdata[15:0] & `SSP_PC_MASK;
                `SSP_OFF_CTRL:
                begin
                    if (pwdata[`SSP_CT_SOFTRST])
                    begin
                        s_d.ctl = `SSP_CT_RST;
                        s_d.port_pin_control = `SSP_PC_RST;
                    end
                    else
                    begin
                        s_d.ctl = pwdata[20:0] & `SSP_CT_MASK;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // individual or stop reset returns every flag to its reset value
        if (port_rst)
        begin
            s_d.if0 = 1'b0;
            s_d.if1 = 1'b0;
            s_d.tx_frame_sync_flag = 1'b0;
            s_d.rx_fsf = 1'b0;
            s_d.und = 1'b0;
            s_d.ovr = 1'b0;
            s_d.rx_full = 1'b0;
            s_d.und_arm = 1'b0;
            s_d.ovr_arm = 1'b0;
            s_d.tx_empty = 1'b1;
            s_d.null_pend = 1'b0;
            s_d.oe = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.port_pin_control <= `SSP_PC_RST;
            s_q.ctl <= `SSP_CT_RST;
            s_q.tx_empty <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = rd_mux;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign tx_data_pin = s_q.pin;
    assign tx_data_pin_oe = s_q.oe;
    assign rx_irq = s_q.ctl[`SSP_CT_RXIE] && s_q.rx_full;
    assign rx_err_irq = s_q.ctl[`SSP_CT_RXERRIE] && s_q.ovr;
    assign tx_irq = s_q.ctl[`SSP_CT_TXIE] && s_q.tx_empty;
    assign tx_err_irq = s_q.ctl[`SSP_CT_TXERRIE] && s_q.und;
endmodule : ssp_top

// ### hdl/ssp_cfg.svh
// constants of the synchronous serial port: offsets, field positions, reset values
// assumes a 32-bit APB slave with a 12-bit byte address and a 10 MHz pclk
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SSP_OFF_STATUS 12'h000
`define SSP_OFF_RXDATA 12'h004
`define SSP_OFF_TXDATA 12'h008
`define SSP_OFF_NULL 12'h00C
`define SSP_OFF_PCR 12'h010
`define SSP_OFF_CTRL 12'h014

// ****************************************
// control register fields
// ****************************************
`define SSP_CT_SYNC 0
`define SSP_CT_NET 1
`define SSP_CT_DIR0 2
`define SSP_CT_DIR1 3
`define SSP_CT_TXEN 4
`define SSP_CT_RXEN 5
`define SSP_CT_TXERRIE 6
`define SSP_CT_RXERRIE 7
`define SSP_CT_TXIE 8
`define SSP_CT_RXIE 9
`define SSP_CT_LSB 10
`define SSP_CT_WL_LO 11
`define SSP_CT_WL_HI 12
`define SSP_CT_SLOT_LO 16
`define SSP_CT_SLOT_HI 20
`define SSP_CT_SOFTRST 31
`define SSP_CT_MASK 21'h1F_1FFF
`define SSP_CT_RST 21'h00_0000

// ****************************************
// port control fields, reset values and word length codes
// ****************************************
`define SSP_PC_PIN0 0
`define SSP_PC_PIN1 1
`define SSP_PC_PEN 7
`define SSP_PC_MASK 16'h00BF
`define SSP_PC_RST 16'h0000
`define SSP_WL8 2'h0
`define SSP_WL12 2'h1

`endif

// ### hdl/ssp_pkg.sv
// types of the synchronous serial port
// assumes ssp_cfg.svh holds the numbers
package ssp_pkg;

    // link inputs, all asynchronous to pclk
    typedef struct packed {
        logic rx_clk;
        logic rx_fs;
        logic rx_data_pin;
        logic tx_clk;
        logic tx_fs;
        logic ctrl_pin_zero;
        logic ctrl_pin_one;
    } ssp_link_t;

    // per-edge events from the slot tracker
    typedef struct packed {
        logic go;
        logic first;
        logic last;
        logic frame;
    } ssp_slot_ev_t;

    typedef struct packed {
        logic active;
        logic [4:0] cnt;
        logic [4:0] slot;
    } ssp_slot_t;

    typedef struct packed {
        ssp_link_t link_a;
        ssp_link_t link_b;
        ssp_link_t link_c;
        logic [15:0] port_pin_control;
        logic [20:0] ctl;
        logic [15:0] rx_sh;
        logic [15:0] rx_data;
        logic rx_full;
        logic rx_fsf;
        logic rx_fcap;
        logic if0;
        logic if1;
        logic cap0;
        logic cap1;
        logic ovr;
        logic ovr_arm;
        logic [15:0] tx_data;
        logic tx_empty;
        logic null_pend;
        logic [15:0] tx_sh;
        logic tx_null;
        logic tx_frame_sync_flag;
        logic und;
        logic und_arm;
        logic pin;
        logic oe;
    } ssp_state_t;

endpackage : ssp_pkg

// ### hdl/ssp_slot.sv
// bit and slot counter for one direction of the serial link
// assumes bit_ev is a one-cycle pulse per link bit clock edge on pclk
`timescale 1ns/1ps
module ssp_slot (
    input wire logic pclk,                    // system clock
    input wire logic presetn,                 // async reset, active low
    input wire logic flush,                   // port held in reset
    input wire logic bit_ev,                  // one bit clock edge seen
    input wire logic fs,                      // synchronised frame sync
    input wire logic network,                 // network mode
    input wire logic [4:0] word_bits,         // 8, 12 or 16
    input wire logic [4:0] last_slot,         // slots per frame minus one
    output ssp_pkg::ssp_slot_ev_t ev          // events of this edge
);
    ssp_pkg::ssp_slot_t s_q;
    ssp_pkg::ssp_slot_t s_d;

    always_comb
    begin
        logic start;
        logic [4:0] slot_now;
        start = 1'b0;
        slot_now = 5'h00;
        s_d = s_q;
        ev = '0;
        start = fs && (!s_q.active || s_q.cnt == 5'h00);
        slot_now = start ? 5'h00 : s_q.slot;
        ev.go = bit_ev && (start || s_q.active);
        ev.first = ev.go && (start || s_q.cnt == 5'h00);
        ev.last = ev.go && !start && s_q.cnt == 5'(word_bits - 5'h01);
        ev.frame = slot_now == 5'h00;
        if (ev.go)
        begin
            if (ev.last)
            begin
                s_d.cnt = 5'h00;
                // network keeps going slot after slot up to last_slot, normal stops after one word
                s_d.active = network && slot_now < last_slot;
                s_d.slot = 5'(slot_now + 5'h01);
            end
            else
            begin
                s_d.cnt = start ? 5'h01 : 5'(s_q.cnt + 5'h01);
                s_d.slot = slot_now;
                s_d.active = 1'b1;
            end
        end
        if (flush)
        begin
            s_d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule : ssp_slot

// ### tb/ssp_props.sv
// checker of status reads and request levels at the serial port's ports
// assumes the ports of ssp_top and the register offsets of ssp_cfg.svh
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_props (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic [11:0] paddr, // address
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // direction
    input wire logic [31:0] prdata, // read data
    input wire logic stop_req, // stop reset
    input wire logic rx_irq, // receive request
    input wire logic rx_err_irq, // overrun request
    input wire logic tx_irq, // transmit request
    input wire logic tx_err_irq // underrun request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_st;
    logic rd_rx;
    logic wr_any;
    logic wr_tx;
    assign rd_st = psel && penable && !pwrite && paddr == `SSP_OFF_STATUS;
    assign rd_rx = psel && penable && !pwrite && paddr == `SSP_OFF_RXDATA;
    assign wr_any = psel && penable && pwrite;
    assign wr_tx = wr_any && (paddr == `SSP_OFF_TXDATA || paddr == `SSP_OFF_NULL);
    a_status_high_zero: assert property (rd_st |-> prdata[31:8] == 24'h0) else $error("status high bits");
    a_full_flag_irq: assert property (rd_st && rx_irq |-> prdata[7]) else $error("rx request flag");
    a_empty_flag_irq: assert property (rd_st && tx_irq |-> prdata[6]) else $error("tx request flag");
    a_ovr_flag_irq: assert property (rd_st && rx_err_irq |-> prdata[5]) else $error("overrun flag");
    a_und_flag_irq: assert property (rd_st && tx_err_irq |-> prdata[4]) else $error("underrun flag");
    a_stop_clears: assert property (stop_req [*3] ##0 rd_st |-> prdata[7:0] == 8'h40) else $error("stop status");
    a_full_clear_cause: assert property ($fell(rx_irq) |->
        stop_req || $past(stop_req) || $past(rd_rx || wr_any)) else $error("rx full dropped");
    a_ovr_clear_cause: assert property ($fell(rx_err_irq) |->
        stop_req || $past(stop_req) || $past(rd_rx || wr_any)) else $error("overrun dropped");
    a_und_clear_cause: assert property ($fell(tx_err_irq) |->
        stop_req || $past(stop_req) || $past(wr_any)) else $error("underrun dropped");
    a_txwr_clears: assert property (wr_tx |=> !tx_irq) else $error("tx empty kept");
endmodule : ssp_props

bind ssp_top ssp_props i_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .stop_req(stop_req), .rx_irq(rx_irq), .rx_err_irq(rx_err_irq),
    .tx_irq(tx_irq), .tx_err_irq(tx_err_irq));

// ### tb/ssp_codec.sv
// far-side codec: makes bit clock and frame sync, sends one word, records the transmit pin
// assumes synchronous mode; the port drives on rising and samples on falling bit clock
`timescale 1ns/1ps
module ssp_codec (
    output logic sclk, // bit clock, still between frames
    output logic fs, // frame sync
    output logic sd, // data toward the port
    output logic c0, // control pin zero
    input wire logic tx_pin, // data from the port
    input wire logic tx_oe, // port drives tx_pin
    output logic [15:0] got, // bits seen, last lowest
    output logic drv // port drove in the frame
);
    initial {sclk, fs, sd, c0, drv, got} = '0;
    task frame(input logic [15:0] w, input int n, input logic f);
        drv = 1'h0;
        for (int i = 0; i < n; i++)
        begin
            // change lines midway in the low phase, well clear of both clock edges
            #200;
            fs = (i == 0);
            sd = w[15 - i];
            c0 = f;
            #200;
            if (i > 0)
            begin
                got = {got[14:0], tx_pin};
                drv = drv | tx_oe;
            end
            sclk = 1'h1;
            #400 sclk = 1'h0;
        end
        #400 got = {got[14:0], tx_pin};
        drv = drv | tx_oe;
        fs = 1'h0;
        // released line shows the inverse of its last bit
        sd = ~sd;
    endtask : frame
endmodule : ssp_codec

// ### tb/ssp_top_tb.sv
// self-checking bench: APB register traffic and framed link traffic through the codec model
// assumes ssp_codec on the link and ssp_props bound to ssp_top
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_top_tb;
    logic pclk = 1'h0;
    logic presetn, psel, penable, pwrite, stop_req, pready, pslverr, e, tx_pin, tx_oe, sclk, fs, sd, c0, drv;
    logic rx_irq, rx_err_irq, tx_irq, tx_err_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] got, m;
    ssp_pkg::ssp_link_t link;
    int fails = 0, total_checks = 0, cyc = 0;
    logic [31:0] base = 32'h3F1;
    logic [31:0] wl [3] = '{32'h1000, 32'h0800, 32'h0000};
    int nb [3] = '{16, 12, 8};
    logic [15:0] tw [3] = '{16'h1234, 16'hABC7, 16'hA5FF};
    logic [15:0] rw [3] = '{16'hBEEF, 16'h5679, 16'hC3A5};
    assign link = {sclk, fs, sd, 1'h0, 1'h0, c0, 1'h0};
    always #50 pclk = ~pclk;
    ssp_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link), .stop_req(stop_req),
        .tx_data_pin(tx_pin), .tx_data_pin_oe(tx_oe), .rx_irq(rx_irq), .rx_err_irq(rx_err_irq), .tx_irq(tx_irq),
        .tx_err_irq(tx_err_irq));
    ssp_codec i_codec (.sclk(sclk), .fs(fs), .sd(sd), .c0(c0), .tx_pin(tx_pin), .tx_oe(tx_oe), .got(got), .drv(drv));
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic r;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            // taken at the edge itself: design flops only update later in this step
            @(posedge pclk);
            q = prdata;
            e = pslverr;
            r = pready;
        end
        while (r !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        total_checks++;
        if (y !== x)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, x, y);
        end
    endtask : chk
    task rd(input logic [11:0] a, input logic [31:0] x, input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, x, q);
    endtask : rd
    task frm(input logic [15:0] w, input int n, input logic f);
        i_codec.frame(w, n, f);
        repeat (4) @(posedge pclk);
    endtask : frm
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            wrap_up;
        end
    end
    initial
    begin
        {psel, penable, pwrite, stop_req, presetn, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h1, `SSP_OFF_PCR, 32'h83);
        rd(`SSP_OFF_STATUS, 32'h40, "status after reset");
        rd(`SSP_OFF_PCR, 32'h83, "port control");
        for (int i = 0; i < 3; i++)
        begin
            m = ~(16'hFFFF >> nb[i]);
            apb(1'h1, `SSP_OFF_CTRL, base | wl[i]);
            apb(1'h1, `SSP_OFF_TXDATA, {16'h0, tw[i]});
            frm(rw[i], nb[i], 1'h1);
            chk("tx word", {16'h0, tw[i] & m}, {16'h0, got << (16 - nb[i])});
            rd(`SSP_OFF_STATUS, 32'hCD, "status after frame");
            rd(`SSP_OFF_RXDATA, {16'h0, rw[i] & m}, "rx word");
        end
        $display("word length test done");
        frm(16'h5A00, 8, 1'h0);
        chk("resent word", 32'hA5, {24'h0, got[7:0]});
        frm(16'h9900, 8, 1'h0);
        chk("requests", 32'hF, {28'h0, rx_err_irq, tx_err_irq, rx_irq, tx_irq});
        rd(`SSP_OFF_RXDATA, 32'h5A00, "kept word");
        rd(`SSP_OFF_STATUS, 32'h7C, "errors held");
        rd(`SSP_OFF_RXDATA, 32'h5A00, "armed rx read");
        apb(1'h1, `SSP_OFF_TXDATA, 32'h3C00);
        rd(`SSP_OFF_STATUS, 32'h0C, "errors cleared");
        $display("error flag test done");
        frm(16'h0000, 8, 1'h1);
        chk("queued word", 32'h3C, {24'h0, got[7:0]});
        rd(`SSP_OFF_RXDATA, 32'h0, "zero word");
        apb(1'h1, `SSP_OFF_CTRL, base | 32'h4);
        apb(1'h1, `SSP_OFF_NULL, 32'h0);
        frm(16'hFF00, 8, 1'h1);
        chk("null slot drive", 32'h0, {31'h0, drv});
        rd(`SSP_OFF_STATUS, 32'hCC, "null slot status");
        rd(`SSP_OFF_RXDATA, 32'hFF00, "null frame word");
        $display("null slot test done");
        apb(1'h1, `SSP_OFF_CTRL, base | 32'h0001_0002);
        apb(1'h1, `SSP_OFF_TXDATA, 32'hC300);
        fork
            frm(16'h5AA5, 16, 1'h0);
            begin
                // lands inside the frame-sync slot
                repeat (20) @(posedge pclk);
                apb(1'h1, `SSP_OFF_TXDATA, 32'h9600);
            end
        join
        chk("network words", 32'hC396, {16'h0, got});
        rd(`SSP_OFF_STATUS, 32'hE8, "network status");
        rd(`SSP_OFF_RXDATA, 32'h5A00, "first slot word");
        $display("network test done");
        apb(1'h1, `SSP_OFF_CTRL, base | 32'h400);
        apb(1'h1, `SSP_OFF_TXDATA, 32'h3000);
        frm(16'h1200, 8, 1'h0);
        chk("lsb tx word", 32'h0C, {24'h0, got[7:0]});
        rd(`SSP_OFF_RXDATA, 32'h4800, "lsb rx word");
        $display("bit order test done");
        stop_req <= 1'h1;
        repeat (3) @(posedge pclk);
        rd(`SSP_OFF_STATUS, 32'h40, "stop status");
        stop_req <= 1'h0;
        apb(1'h0, 12'h018, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'h1, `SSP_OFF_CTRL, 32'h8000_0000);
        rd(`SSP_OFF_PCR, 32'h0, "port control after soft reset");
        $display("reset test done");
        wrap_up;
    end
endmodule : ssp_top_tb
